// ===== src/pio_produced_image.sv
// Functional notes
// - poll answered at once with produced image
// - strobe, cyclic, change-of-state not serviced
// - explicit get/set to any parameter when idle
// - four 16-bit words each direction
// - image refreshed on every network scan
// - default layout under selection 101
// - bit 0 forward running
// - bit 1 reverse running
// - bit 2 uncleared trip
// - bit 4 frequency arrival
// - bits 5..7 input terminals 1..3
// - byte 1 carries state code
// - codes 0..4 basic states
// - codes 5..8 power-loss restart
// - code 9 saving, stop/reset ignored
// - code 10 trip, 11 undervoltage
// - auto-tune codes 101..116
// - bytes 2,3 frequency low then high
// - bytes 4,5 current low then high
// - byte 6 trip error code
// - selections 70 and 71 alternative layouts
// - selection accepts 70, 71, 101 only
`default_nettype none
module pio_produced_image #(
   parameter int PARAM_DEPTH = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              net_active,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   input  wire logic              rx_last,
   input  wire pio_pkg::pio_kind_t rx_kind,
   output logic                   rx_ready,
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   output logic                   tx_last,
   input  wire logic              tx_ready,
   input  wire logic              forward_running_flag,
   input  wire logic              reverse_running_flag,
   input  wire logic              trip_active,
   input  wire logic              freq_arrived,
   input  wire logic [2:0]        input_term,
   input  wire logic [15:0]       out_freq,
   input  wire logic [15:0]       out_current,
   input  wire logic [7:0]        trip_code,
   input  wire logic              tune_active,
   input  wire logic [3:0]        tune_step,
   input  wire logic              tune_ok,
   input  wire logic              tune_fail,
   input  wire logic              trip_saving,
   input  wire logic              undervolt,
   input  wire logic              restart_wait,
   input  wire logic              pwr_loss_halt,
   input  wire logic              freq_matching,
   input  wire logic              restart_opt,
   input  wire logic              dc_braking,
   input  wire logic              coasting,
   input  wire logic              jogging,
   input  wire logic              running,
   input  wire logic              stop_reset_req,
   output logic                   trip_clear,
   output logic [63:0]            consumed_image,
   output logic                   poll_done,
   output logic                   kind_refused,
   output logic                   frame_error,
   output logic [7:0]             inst_sel
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_RX_POLL,
      S_RX_EXP,
      S_DROP,
      S_TX
   } pio_fsm_t;

   // =========================================================
   // state and storage
   pio_fsm_t           state_q;
   pio_fsm_t           state_d;
   logic [3:0]         cnt_q;
   logic [7:0]         rx_buf_q [pio_pkg::IMG_BYTES];
   logic [7:0]         tx_buf_q [pio_pkg::IMG_BYTES];
   logic [3:0]         tx_idx_q;
   logic [3:0]         tx_len_q;
   logic [63:0]        cons_q;
   logic               poll_done_q;
   logic               refused_q;
   logic               ferr_q;
   logic               clear_q;

   // =========================================================
   // receive decode
   logic               rx_take;
   logic               first;
   logic               frame_end;
   logic               is_poll;
   logic               is_exp;
   logic               poll_ok;
   logic               exp_ok;
   logic               op_get;
   logic               op_set;
   logic [7:0]         fb [pio_pkg::IMG_BYTES];
   logic [7:0]         code;
   logic [7:0]         prod [pio_pkg::IMG_BYTES];
   logic [7:0]         flags;
   logic [15:0]        p_rdata;
   logic               p_wr_ok;
   logic               p_wr;
   logic               tx_fire;
   logic               fsm_kind_poll;
   logic               fsm_kind_exp;

   assign rx_take  = rx_valid && rx_ready;
   assign first    = state_q == S_IDLE;
   assign fsm_kind_poll = first ? (rx_kind == pio_pkg::KIND_POLL) : (state_q == S_RX_POLL);
   assign fsm_kind_exp  = first ? (rx_kind == pio_pkg::KIND_EXPLICIT) : (state_q == S_RX_EXP);
   // a poll only counts while the network runs
   assign is_poll  = fsm_kind_poll && net_active;
   assign is_exp   = fsm_kind_exp;
   assign frame_end = rx_take && rx_last && (state_q != S_DROP);
   assign poll_ok  = frame_end && is_poll && (cnt_q == pio_pkg::IMG_LAST);
   assign exp_ok   = frame_end && is_exp && (cnt_q == pio_pkg::EXP_LAST);
   assign op_get   = exp_ok && (fb[0] == pio_pkg::OP_GET);
   assign op_set   = exp_ok && (fb[0] == pio_pkg::OP_SET);
   assign p_wr     = op_set;

   // the byte on the bus completes the frame, so merge it with the stored ones
   generate
      for (genvar g = 0; g < pio_pkg::IMG_BYTES; g++) begin : g_fb
         assign fb[g] = (cnt_q == 4'(g)) ? rx_data : rx_buf_q[g];
      end
   endgenerate

   // =========================================================
   // produced image content
   pio_state_code u_code (
      .tune_active   (tune_active),
      .tune_step     (tune_step),
      .tune_ok       (tune_ok),
      .tune_fail     (tune_fail),
      .trip_saving   (trip_saving),
      .tripped       (trip_active),
      .undervolt     (undervolt),
      .restart_wait  (restart_wait),
      .pwr_loss_halt (pwr_loss_halt),
      .freq_matching (freq_matching),
      .restart_opt   (restart_opt),
      .dc_braking    (dc_braking),
      .coasting      (coasting),
      .jogging       (jogging),
      .running       (running),
      .code          (code)
   );

   assign flags = {input_term,
                   freq_arrived,
                   1'b0,
                   trip_active,
                   reverse_running_flag,
                   forward_running_flag};

   always_comb begin
      for (int i = 0; i < pio_pkg::IMG_BYTES; i++) prod[i] = 8'h00;
      prod[0] = flags;
      prod[2] = out_freq[7:0];
      prod[3] = out_freq[15:8];
      if (inst_sel == pio_pkg::INST_ALT_B) begin
         prod[1] = code;
      end else if (inst_sel != pio_pkg::INST_ALT_A) begin
         prod[1] = code;
         // frequency low then high above; current
         prod[4] = out_current[7:0];
         prod[5] = out_current[15:8];
         prod[6] = trip_code;
      end
   end

   // =========================================================
   // explicit parameter access
   // explicit get and set
   pio_param_bank #(
      .DEPTH (PARAM_DEPTH)
   ) u_bank (
      .clk      (clk),
      .rst      (rst),
      .wr_en    (p_wr),
      .idx      (fb[1]),
      .wdata    ({fb[3], fb[2]}),
      .rdata    (p_rdata),
      .wr_ok    (p_wr_ok),
      .inst_sel (inst_sel)
   );

   // =========================================================
   // frame sequencing
   assign tx_fire = tx_valid && tx_ready;

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (rx_take) begin
               if (rx_last) state_d = (poll_ok || op_get || op_set) ? S_TX : S_IDLE;
               else if (is_poll) state_d = S_RX_POLL;
               else if (is_exp) state_d = S_RX_EXP;
               else state_d = S_DROP;
            end
         end
         S_RX_POLL,
         S_RX_EXP: begin
            if (frame_end) state_d = (poll_ok || op_get || op_set) ? S_TX : S_IDLE;
            else if (rx_take && cnt_q == pio_pkg::IMG_LAST) state_d = S_DROP;
         end
         S_DROP: begin
            if (rx_take && rx_last) state_d = S_IDLE;
         end
         S_TX: begin
            if (tx_fire && tx_last) state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   // explicit requests only fit in idle time: no intake while replying
   assign rx_ready = state_q != S_TX;
   // reply follows the poll with no further request
   assign tx_valid = state_q == S_TX;
   assign tx_data  = tx_buf_q[tx_idx_q[2:0]];
   assign tx_last  = tx_idx_q == (tx_len_q - 4'h1);

   always_ff @(posedge clk) begin
      if (rst) state_q <= S_IDLE;
      else state_q <= state_d;
   end

   always_ff @(posedge clk) begin
      if (rst) cnt_q <= 4'h0;
      else if (state_d == S_IDLE || state_d == S_TX) cnt_q <= 4'h0;
      else if (rx_take && cnt_q != pio_pkg::IMG_LAST) cnt_q <= cnt_q + 4'h1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < pio_pkg::IMG_BYTES; i++) rx_buf_q[i] <= 8'h00;
      end else if (rx_take) begin
         rx_buf_q[cnt_q[2:0]] <= rx_data;
      end
   end

   // consumed words, byte 0 is the low byte of word 0
   always_ff @(posedge clk) begin
      if (rst) cons_q <= 64'h0;
      else if (poll_ok) cons_q <= {fb[7], fb[6], fb[5], fb[4], fb[3], fb[2], fb[1], fb[0]};
   end

   // a fresh snapshot is taken at each completed poll
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < pio_pkg::IMG_BYTES; i++) tx_buf_q[i] <= 8'h00;
         tx_len_q <= 4'h0;
      end else if (poll_ok) begin
         for (int i = 0; i < pio_pkg::IMG_BYTES; i++) tx_buf_q[i] <= prod[i];
         tx_len_q <= 4'(pio_pkg::IMG_BYTES);
      end else if (op_get) begin
         tx_buf_q[0] <= p_rdata[7:0];
         tx_buf_q[1] <= p_rdata[15:8];
         tx_len_q    <= 4'h2;
      end else if (op_set) begin
         tx_buf_q[0] <= p_wr_ok ? pio_pkg::EXP_OK : pio_pkg::EXP_ERR;
         tx_len_q    <= 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) tx_idx_q <= 4'h0;
      else if (state_q != S_TX) tx_idx_q <= 4'h0;
      else if (tx_fire) tx_idx_q <= tx_idx_q + 4'h1;
   end

   // =========================================================
   // event pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         poll_done_q <= 1'b0;
         refused_q   <= 1'b0;
         ferr_q      <= 1'b0;
         clear_q     <= 1'b0;
      end else begin
         poll_done_q <= poll_ok;
         // other exchange kinds refused at their first byte
         refused_q   <= rx_take && first && !is_poll && !is_exp;
         ferr_q      <= frame_end && (is_poll || is_exp) && !poll_ok && !op_get && !op_set;
         // stop/reset ignored while the history is saved
         clear_q     <= stop_reset_req && (code != pio_pkg::ST_TRIP_SAVE);
      end
   end

   assign consumed_image = cons_q;
   assign poll_done      = poll_done_q;
   assign kind_refused   = refused_q;
   assign frame_error    = ferr_q;
   assign trip_clear     = clear_q;
endmodule : pio_produced_image
`default_nettype wire

// ===== common/pio_pkg.sv
`default_nettype none
package pio_pkg;
   // =========================================================
   // image shape
   localparam int        IMG_BYTES      = 8;
   localparam int        IMG_WORDS      = 4;
   localparam int        WORD_W         = 16;
   localparam int        EXP_BYTES      = 4;
   localparam logic [3:0] IMG_LAST      = 4'h7;
   localparam logic [3:0] EXP_LAST      = 4'h3;
   // =========================================================
   // produced-instance selection values
   localparam logic [7:0] INST_DEFAULT  = 8'h65;
   localparam logic [7:0] INST_ALT_A    = 8'h46;
   localparam logic [7:0] INST_ALT_B    = 8'h47;
   // =========================================================
   // flag byte bit positions
   localparam int        B0_FWD         = 0;
   localparam int        B0_REV         = 1;
   localparam int        B0_TRIP        = 2;
   localparam int        B0_ARRIVE      = 4;
   localparam int        B0_TERM1       = 5;
   // =========================================================
   // state codes
   localparam logic [7:0] ST_STOP       = 8'h00;
   localparam logic [7:0] ST_RUN        = 8'h01;
   localparam logic [7:0] ST_JOG        = 8'h02;
   localparam logic [7:0] ST_COAST      = 8'h03;
   localparam logic [7:0] ST_DCBRAKE    = 8'h04;
   localparam logic [7:0] ST_MATCH_A    = 8'h05;
   localparam logic [7:0] ST_PWR_HALT   = 8'h06;
   localparam logic [7:0] ST_MATCH_B    = 8'h07;
   localparam logic [7:0] ST_RST_WAIT   = 8'h08;
   localparam logic [7:0] ST_TRIP_SAVE  = 8'h09;
   localparam logic [7:0] ST_TRIP       = 8'h0a;
   localparam logic [7:0] ST_UNDERVOLT  = 8'h0b;
   localparam logic [7:0] ST_TUNE_BASE  = 8'h65;
   localparam logic [3:0] TUNE_MAX_STEP = 4'hd;
   localparam logic [7:0] ST_TUNE_OK    = 8'h73;
   localparam logic [7:0] ST_TUNE_FAIL  = 8'h74;
   // =========================================================
   // explicit messages
   localparam logic [7:0] OP_GET        = 8'h00;
   localparam logic [7:0] OP_SET        = 8'h01;
   localparam logic [7:0] EXP_OK        = 8'h00;
   localparam logic [7:0] EXP_ERR       = 8'h01;
   localparam logic [7:0] PARAM_INST    = 8'h00;
   // =========================================================
   // exchange kinds offered by the link layer
   typedef enum logic [2:0] {
      KIND_POLL,
      KIND_STROBE,
      KIND_CYCLIC,
      KIND_COS,
      KIND_EXPLICIT
   } pio_kind_t;
endpackage : pio_pkg
`default_nettype wire

// ===== src/pio_state_code.sv
`default_nettype none
module pio_state_code (
   input  wire logic       tune_active,
   input  wire logic [3:0] tune_step,
   input  wire logic       tune_ok,
   input  wire logic       tune_fail,
   input  wire logic       trip_saving,
   input  wire logic       tripped,
   input  wire logic       undervolt,
   input  wire logic       restart_wait,
   input  wire logic       pwr_loss_halt,
   input  wire logic       freq_matching,
   input  wire logic       restart_opt,
   input  wire logic       dc_braking,
   input  wire logic       coasting,
   input  wire logic       jogging,
   input  wire logic       running,
   output logic [7:0]      code
);
   logic [3:0] step_clamped;

   assign step_clamped = (tune_step > pio_pkg::TUNE_MAX_STEP) ? pio_pkg::TUNE_MAX_STEP
                                                              : tune_step;

   // tuning and faults outrank motion so a trip is never hidden by a motion state; tuning and history saving still outrank it
   always_comb begin
      if (tune_fail) code = pio_pkg::ST_TUNE_FAIL;
      else if (tune_ok) code = pio_pkg::ST_TUNE_OK;
      else if (tune_active) code = pio_pkg::ST_TUNE_BASE + {4'h0, step_clamped};
      else if (trip_saving) code = pio_pkg::ST_TRIP_SAVE;
      else if (tripped) code = pio_pkg::ST_TRIP;
      else if (undervolt) code = pio_pkg::ST_UNDERVOLT;
      else if (restart_wait) code = pio_pkg::ST_RST_WAIT;
      else if (pwr_loss_halt) code = pio_pkg::ST_PWR_HALT;
      else if (freq_matching) code = restart_opt ? pio_pkg::ST_MATCH_A : pio_pkg::ST_MATCH_B;
      else if (dc_braking) code = pio_pkg::ST_DCBRAKE;
      else if (coasting) code = pio_pkg::ST_COAST;
      else if (jogging) code = pio_pkg::ST_JOG;
      else if (running) code = pio_pkg::ST_RUN;
      else code = pio_pkg::ST_STOP;
   end
endmodule : pio_state_code
`default_nettype wire

// ===== src/pio_param_bank.sv
`default_nettype none
module pio_param_bank #(
   parameter int DEPTH = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [7:0]  idx,
   input  wire logic [15:0] wdata,
   output logic [15:0]      rdata,
   output logic             wr_ok,
   output logic [7:0]       inst_sel
);
   logic [15:0] mem_q [DEPTH];
   logic        idx_ok;
   logic        is_inst;
   logic        inst_legal;

   assign idx_ok     = idx < 8'(DEPTH);
   assign is_inst    = idx == pio_pkg::PARAM_INST;
   assign inst_legal = (wdata == {8'h00, pio_pkg::INST_DEFAULT})
                    || (wdata == {8'h00, pio_pkg::INST_ALT_A})
                    || (wdata == {8'h00, pio_pkg::INST_ALT_B});
   assign wr_ok      = idx_ok && (!is_inst || inst_legal);
   assign rdata      = idx_ok ? mem_q[idx[$clog2(DEPTH)-1:0]] : 16'h0000;
   assign inst_sel   = mem_q[0][7:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= 16'h0000;
         mem_q[0] <= {8'h00, pio_pkg::INST_DEFAULT};
      end else if (wr_en && wr_ok) begin
         mem_q[idx[$clog2(DEPTH)-1:0]] <= wdata;
      end
   end
endmodule : pio_param_bank
`default_nettype wire

// ===== dv/pio_master_model.sv
`default_nettype none
module pio_master_model (
   input  wire logic         clk,
   output logic              rx_valid,
   output logic [7:0]        rx_data,
   output logic              rx_last,
   output pio_pkg::pio_kind_t rx_kind,
   input  wire logic         rx_ready,
   input  wire logic         tx_valid,
   input  wire logic [7:0]   tx_data,
   input  wire logic         tx_last,
   output logic              tx_ready,
   input  wire logic         slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rep [0:15];
   int         rep_n;
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
      rx_kind  = pio_pkg::KIND_POLL;
      tx_ready = 1'b1;
      rep_n    = 0;
   end
   // a slow scanner takes a reply byte only every other cycle
   always @(negedge clk) tx_ready <= slow ? !tx_ready : 1'b1;
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         rep[rep_n[3:0]] <= tx_data;
         rep_n <= rep_n + 1;
      end
   end
   task automatic clr();
      rep_n = 0;
   endtask : clr
   task automatic send(input pio_pkg::pio_kind_t k, input logic [63:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data  = f[8*i +: 8];
         rx_last  = (i == n - 1);
         rx_kind  = k;
         while (rx_ready !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      // released data line shows no stale byte
      rx_data  = ~rx_data;
   endtask : send
endmodule : pio_master_model
`default_nettype wire

// ===== dv/pio_produced_image_asserts.sv
`default_nettype none
module pio_produced_image_asserts (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               rx_valid,
   input wire logic               rx_last,
   input wire pio_pkg::pio_kind_t rx_kind,
   input wire logic               rx_ready,
   input wire logic               tx_valid,
   input wire logic [7:0]         tx_data,
   input wire logic               tx_last,
   input wire logic               tx_ready,
   input wire logic               tune_active,
   input wire logic               tune_ok,
   input wire logic               tune_fail,
   input wire logic               trip_saving,
   input wire logic               stop_reset_req,
   input wire logic               trip_clear,
   input wire logic               poll_done,
   input wire logic               kind_refused,
   input wire logic [7:0]         inst_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic       in_frame_q;
   logic       poll_rep_q;
   logic [3:0] tx_idx_q;
   logic       rx_take;
   logic       tx_take;
   logic       odd_kind;
   logic       is_poll;
   logic       dflt;
   assign rx_take  = rx_valid && rx_ready;
   assign tx_take  = tx_valid && tx_ready;
   assign odd_kind = rx_kind inside {pio_pkg::KIND_STROBE, pio_pkg::KIND_CYCLIC,
                                     pio_pkg::KIND_COS};
   assign is_poll  = poll_done || poll_rep_q;
   assign dflt     = is_poll && tx_valid && inst_sel == pio_pkg::INST_DEFAULT;
   // tracks frame start and reply byte position
   always_ff @(posedge clk) begin
      if (rst) begin
         in_frame_q <= 1'b0;
         poll_rep_q <= 1'b0;
         tx_idx_q   <= 4'h0;
      end else begin
         if (rx_take) in_frame_q <= !rx_last;
         if (tx_take) tx_idx_q <= tx_last ? 4'h0 : tx_idx_q + 4'h1;
         if (tx_take && tx_last) poll_rep_q <= 1'b0;
         else if (poll_done) poll_rep_q <= 1'b1;
      end
   end
   chk_poll_reply: assert property (poll_done |-> tx_valid && !rx_ready)
      else $error("poll not answered at once");
   chk_reply_cause: assert property (poll_done |-> $past(rx_take) && $past(rx_last))
      else $error("reply without a finished poll");
   chk_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped while stalled");
   chk_kind_drop: assert property (rx_take && !in_frame_q && odd_kind |=> kind_refused)
      else $error("unsupported exchange not refused");
   chk_refuse_quiet: assert property (kind_refused |-> !tx_valid && !poll_done)
      else $error("refused exchange answered");
   chk_poll_len: assert property (is_poll && tx_take && tx_last |-> tx_idx_q == 4'h7)
      else $error("poll reply not eight bytes");
   chk_last_zero: assert property (dflt && tx_idx_q == 4'h7 |-> tx_data == 8'h00)
      else $error("byte 7 not zero");
   chk_bit3_zero: assert property (dflt && tx_idx_q == 4'h0 |-> !tx_data[3])
      else $error("flag bit 3 not zero");
   chk_inst_legal: assert property (inst_sel inside {8'h46, 8'h47, 8'h65})
      else $error("illegal instance selection");
   chk_save_ignore: assert property (stop_reset_req && trip_saving && !tune_active &&
      !tune_ok && !tune_fail |=> !trip_clear)
      else $error("trip cleared while saving");
   chk_clear_cause: assert property (trip_clear |-> $past(stop_reset_req))
      else $error("trip clear without request");
   cov_poll: cover property (poll_done);
   cov_refuse: cover property (kind_refused);
   cov_clear: cover property (trip_clear);
endmodule : pio_produced_image_asserts
bind pio_produced_image pio_produced_image_asserts chk_u (
   .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_last(rx_last), .rx_kind(rx_kind),
   .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
   .tx_ready(tx_ready), .tune_active(tune_active), .tune_ok(tune_ok),
   .tune_fail(tune_fail), .trip_saving(trip_saving), .stop_reset_req(stop_reset_req),
   .trip_clear(trip_clear), .poll_done(poll_done), .kind_refused(kind_refused),
   .inst_sel(inst_sel));
`default_nettype wire

// ===== dv/polled_io_produced_image_tb.sv
`default_nettype none
module polled_io_produced_image_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, net_active, fwd, rev, freq_arrived, restart_opt, stop_reset_req, slow;
   logic [2:0] input_term;
   logic [3:0] tune_step;
   logic [7:0] trip_code, inst_sel;
   logic [12:0] st;
   logic [15:0] out_freq, out_current;
   logic [63:0] consumed_image, cmd;
   logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   logic trip_clear, poll_done, kind_refused, frame_error;
   logic [7:0] rx_data, tx_data;
   pio_pkg::pio_kind_t rx_kind;
   int n_mismatch, checks, cyc;
   // state codes for one-hot st, running first
   logic [7:0] codes [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0b,
                              8'h0a, 8'h09, 8'h72, 8'h73, 8'h74};
   pio_produced_image #(.PARAM_DEPTH(16)) dut_u (.clk, .rst, .net_active, .rx_valid,
      .rx_data, .rx_last, .rx_kind, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready,
      .forward_running_flag(fwd), .reverse_running_flag(rev), .trip_active(st[8]),
      .freq_arrived, .input_term, .out_freq, .out_current, .trip_code,
      .tune_active(st[10]), .tune_step, .tune_ok(st[11]), .tune_fail(st[12]),
      .trip_saving(st[9]), .undervolt(st[7]), .restart_wait(st[6]),
      .pwr_loss_halt(st[5]), .freq_matching(st[4]), .restart_opt, .dc_braking(st[3]),
      .coasting(st[2]), .jogging(st[1]), .running(st[0]), .stop_reset_req, .trip_clear,
      .consumed_image, .poll_done, .kind_refused, .frame_error, .inst_sel);
   pio_master_model m_u (.clk, .rx_valid, .rx_data, .rx_last, .rx_kind, .rx_ready,
      .tx_valid, .tx_data, .tx_last, .tx_ready, .slow);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // =====================================
   // compare and transfer tasks
   task automatic conclude();
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   function automatic logic [63:0] img(input logic [7:0] code, input logic [7:0] sel);
      logic [7:0] b0;
      b0 = {input_term, freq_arrived, 1'b0, st[8], rev, fwd};
      if (sel == pio_pkg::INST_DEFAULT) return {8'h00, trip_code, out_current, out_freq, code, b0};
      return {32'h0, out_freq, (sel == pio_pkg::INST_ALT_B) ? code : 8'h00, b0};
   endfunction : img
   task automatic wait_reply(input int n);
      int k;
      k = 0;
      while (m_u.rep_n < n && k < 50) begin
         @(negedge clk);
         k++;
      end
      repeat (3) @(negedge clk);
      cmp(64'(m_u.rep_n), 64'(n));
   endtask : wait_reply
   task automatic poll(input logic [63:0] exp);
      logic [63:0] got;
      cmd = cmd + 64'h1111111111111111;
      m_u.clr();
      m_u.send(pio_pkg::KIND_POLL, cmd, 8);
      cmp(poll_done, 1'b1);
      cmp(consumed_image, cmd);
      wait_reply(8);
      for (int i = 0; i < 8; i++) got[8*i +: 8] = m_u.rep[i];
      cmp(got, exp);
   endtask : poll
   task automatic xmsg(input logic [7:0] op, input logic [7:0] idx, input logic [15:0] d,
                       input int n, input logic [15:0] exp);
      m_u.clr();
      m_u.send(pio_pkg::KIND_EXPLICIT, {32'h0, d, idx, op}, 4);
      wait_reply(n);
      cmp(n == 1 ? {56'h0, m_u.rep[0]} : {48'h0, m_u.rep[1], m_u.rep[0]}, {48'h0, exp});
   endtask : xmsg
   task automatic req(input logic exp);
      stop_reset_req = 1'b1;
      @(negedge clk);
      stop_reset_req = 1'b0;
      cmp(trip_clear, exp);
   endtask : req
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         conclude();
      end
   end
   // =====================================
   // main sequence
   initial begin
      {rst, net_active, fwd, rev, freq_arrived, restart_opt, stop_reset_req, slow} = 8'hc4;
      {input_term, tune_step, trip_code, st, out_freq, out_current} = '0;
      cmd = 64'h0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      cmp(inst_sel, pio_pkg::INST_DEFAULT);
      cmp({tx_valid, rx_ready, consumed_image}, {2'b01, 64'h0});
      {fwd, freq_arrived, input_term, tune_step} = {5'h1b, 4'hf};
      {out_freq, out_current, trip_code} = {16'h1234, 16'habcd, 8'h5a};
      poll(img(8'h00, pio_pkg::INST_DEFAULT));
      {fwd, rev, slow, input_term} = 6'h1e;
      poll(img(8'h00, pio_pkg::INST_DEFAULT));
      slow = 1'b0;
      for (int i = 0; i < 13; i++) begin
         st = 13'h1 << i;
         poll(img(codes[i], pio_pkg::INST_DEFAULT));
      end
      {st, restart_opt} = {13'h10, 1'b0};
      poll(img(8'h07, pio_pkg::INST_DEFAULT));
      st = 13'h200;
      req(1'b0);
      st = 13'h100;
      req(1'b1);
      for (int j = 1; j < 4; j++) begin
         m_u.clr();
         m_u.send(pio_pkg::pio_kind_t'(j), cmd, 1);
         cmp(kind_refused, 1'b1);
         wait_reply(0);
      end
      net_active = 1'b0;
      m_u.send(pio_pkg::KIND_POLL, cmd, 8);
      cmp(poll_done, 1'b0);
      wait_reply(0);
      net_active = 1'b1;
      m_u.send(pio_pkg::KIND_POLL, cmd, 7);
      cmp(frame_error, 1'b1);
      xmsg(pio_pkg::OP_SET, pio_pkg::PARAM_INST, 16'h0046, 1, 16'h0000);
      poll(img(8'h0a, pio_pkg::INST_ALT_A));
      xmsg(pio_pkg::OP_SET, pio_pkg::PARAM_INST, 16'h0047, 1, 16'h0000);
      poll(img(8'h0a, pio_pkg::INST_ALT_B));
      xmsg(pio_pkg::OP_SET, pio_pkg::PARAM_INST, 16'h0033, 1, 16'h0001);
      cmp(inst_sel, pio_pkg::INST_ALT_B);
      xmsg(pio_pkg::OP_SET, pio_pkg::PARAM_INST, 16'h0065, 1, 16'h0000);
      xmsg(pio_pkg::OP_GET, pio_pkg::PARAM_INST, 16'h0000, 2, 16'h0065);
      xmsg(pio_pkg::OP_SET, 8'h0f, 16'hbeef, 1, 16'h0000);
      xmsg(pio_pkg::OP_GET, 8'h0f, 16'h0000, 2, 16'hbeef);
      xmsg(pio_pkg::OP_SET, 8'h10, 16'h1111, 1, 16'h0001);
      poll(img(8'h0a, pio_pkg::INST_DEFAULT));
      conclude();
   end
endmodule : polled_io_produced_image_tb
`default_nettype wire
